/* File: src/kms_scanner.sv */
// Purpose: Automatic scanner for a passive key switch matrix.
// Assumes: Column inputs are synchronous to clk_in and read low when no
//          key joins them to a high row.
// Notes:   No software registers; the debounce count is a plain input.
// Summary of operation
// - In idle every row output is held high and nothing is scanned.
// - Idle is left when any column input changes.
// - A scan raises exactly one row at a time and samples all columns.
// - After debouncing the full state is stored, then an irq is raised.
// - After a report the matrix is scanned on for presses or releases.
// - Every new stored state is followed by a fresh interrupt request.
// - The matrix is eight rows by eight columns, 64 keys at most.
// - Each of the 64 key positions is stored in its own bit.
// - A column change seen in idle gives a wake-up pulse usable in the stop state.
// - The block is meant for the always-on slow clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "kms_map.svh"

module kms_scanner #(
  parameter int ROWS  = 8,
  parameter int COLS  = 8,
  parameter int DEB_W = 16
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // Key matrix pins
  output logic [ROWS-1:0]         row_drive_out,
  input  wire logic [COLS-1:0]    col_sense_in,
  // Control
  input  wire logic [DEB_W-1:0]   debounce_scans_in,
  // Status and events
  output logic [ROWS*COLS-1:0]    key_matrix_out,
  output logic                    key_irq_out,
  output logic                    wake_out,
  output logic                    scan_busy_out
);

  localparam int KEYS  = ROWS * COLS;
  localparam int ROW_W = 3;

  // Row index and key matrix sizes are fixed by the constant map.
  if (ROWS != 8 || COLS != 8 || DEB_W != 16) begin : g_size_check
    $error("kms_scanner serves only an 8 by 8 matrix, 16-bit debounce");
  end

  typedef struct packed {
    kms_pkg::kms_fsm_type  fsm;
    logic                  phase;
    logic [ROW_W-1:0]      row;
    logic [ROWS-1:0]       rows;
    logic [COLS-1:0]       col_prev;
    logic [KEYS-1:0]       snap;
    logic [KEYS-1:0]       last_snap;
    logic [KEYS-1:0]       matrix;
    logic [DEB_W-1:0]      stable;
    logic                  irq_pend;
    logic                  irq;
    logic                  wake;
  } kms_state_type;

  kms_state_type st_ff;
  kms_state_type nxt_st;

  function automatic logic [ROWS-1:0] row_onehot(input logic [ROW_W-1:0] r);
    row_onehot = {{(ROWS-1){1'b0}}, 1'b1} << r;
  endfunction : row_onehot

  logic [KEYS-1:0]  scan_word;
  logic [DEB_W-1:0] stable_inc;
  logic             scan_end;
  logic             accept;

  always_comb begin
    scan_word = st_ff.snap;
    scan_word[st_ff.row*COLS +: COLS] = col_sense_in;
    scan_end = (st_ff.fsm == kms_pkg::KMS_SCAN) &&
               (st_ff.phase == `KMS_PHASE_SAMPLE) &&
               (st_ff.row == ROW_W'(ROWS-1));
    // The counter saturates so a held key never wraps into a re-accept.
    stable_inc = (st_ff.stable == {DEB_W{1'b1}}) ? st_ff.stable
                                                 : st_ff.stable + 1'b1;
    accept = 1'b0;

    nxt_st          = st_ff;
    nxt_st.irq      = st_ff.irq_pend;
    nxt_st.irq_pend = 1'b0;
    nxt_st.wake     = 1'b0;

    case (st_ff.fsm)
      kms_pkg::KMS_IDLE: begin
        nxt_st.rows     = {ROWS{1'b1}};
        nxt_st.col_prev = col_sense_in;
        nxt_st.phase    = 1'b1;
        // The first idle cycle only learns the columns, because col_prev still
        // holds a stale value from before the scan and would fake a change.
        if (st_ff.phase && col_sense_in != st_ff.col_prev) begin
          nxt_st.fsm    = kms_pkg::KMS_SCAN;
          nxt_st.row    = `KMS_ROW_FIRST;
          nxt_st.rows   = row_onehot(`KMS_ROW_FIRST);
          nxt_st.phase  = `KMS_PHASE_SETTLE;
          nxt_st.stable = `KMS_STABLE_RST;
          nxt_st.wake   = 1'b1;
        end
      end
      kms_pkg::KMS_SCAN: begin
        if (st_ff.phase == `KMS_PHASE_SETTLE) begin
          nxt_st.phase = `KMS_PHASE_SAMPLE;
        end else begin
          nxt_st.snap  = scan_word;
          nxt_st.phase = `KMS_PHASE_SETTLE;
          nxt_st.row   = st_ff.row + 1'b1;
          nxt_st.rows  = row_onehot(nxt_st.row);
          if (scan_end) begin
            nxt_st.last_snap = scan_word;
            if (scan_word == st_ff.last_snap) begin
              nxt_st.stable = stable_inc;
            end else begin
              nxt_st.stable = `KMS_STABLE_RST;
            end
            accept = (scan_word == st_ff.last_snap) &&
                     (stable_inc >= debounce_scans_in);
            if (accept && scan_word != st_ff.matrix) begin
              nxt_st.matrix   = scan_word;
              nxt_st.irq_pend = 1'b1;
            end else if (accept && scan_word == `KMS_MATRIX_RST &&
                         st_ff.matrix == `KMS_MATRIX_RST) begin
              // Only a settled, already reported empty matrix rests.
              nxt_st.fsm   = kms_pkg::KMS_IDLE;
              nxt_st.rows  = {ROWS{1'b1}};
              nxt_st.phase = 1'b0;
            end
            // Otherwise scanning goes on for extra presses or releases.
          end
        end
      end
      default: begin
        nxt_st.fsm   = kms_pkg::KMS_IDLE;
        nxt_st.rows  = {ROWS{1'b1}};
        nxt_st.phase = 1'b0;
      end
    endcase
  end

  // Nothing is gated, so scanning runs whenever the slow clock does.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff.fsm       <= kms_pkg::KMS_IDLE;
      st_ff.phase     <= 1'b0;
      st_ff.row       <= `KMS_ROW_FIRST;
      st_ff.rows      <= {ROWS{1'b1}};
      st_ff.col_prev  <= {COLS{1'b0}};
      st_ff.snap      <= `KMS_MATRIX_RST;
      st_ff.last_snap <= `KMS_MATRIX_RST;
      st_ff.matrix    <= `KMS_MATRIX_RST;
      st_ff.stable    <= `KMS_STABLE_RST;
      st_ff.irq_pend  <= 1'b0;
      st_ff.irq       <= 1'b0;
      st_ff.wake      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign row_drive_out  = st_ff.rows;
  assign key_matrix_out = st_ff.matrix;
  assign key_irq_out    = st_ff.irq;
  assign wake_out       = st_ff.wake;
  assign scan_busy_out  = (st_ff.fsm == kms_pkg::KMS_SCAN);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_idle_rows_high: assert property (
    (st_ff.fsm == kms_pkg::KMS_IDLE) |-> (row_drive_out == {ROWS{1'b1}}))
    else $error("Rows not all high while idle.");

  a_idle_exit_cause: assert property (
    (st_ff.fsm == kms_pkg::KMS_IDLE) && st_ff.phase &&
    (col_sense_in != st_ff.col_prev) |=> scan_busy_out && wake_out)
    else $error("Column change did not start a scan.");

  a_idle_stays_put: assert property (
    (st_ff.fsm == kms_pkg::KMS_IDLE) && st_ff.phase &&
    (col_sense_in == st_ff.col_prev) |=> !scan_busy_out)
    else $error("Scanner left idle without a column change.");

  a_scan_one_row: assert property (
    scan_busy_out |-> $onehot(row_drive_out))
    else $error("Scan does not drive exactly one row.");

  a_row_walk: assert property (
    scan_busy_out && st_ff.phase && !scan_end
    |=> row_drive_out == ($past(row_drive_out) << 1))
    else $error("Row walk skipped or repeated a row.");

  a_store_then_irq: assert property (
    $changed(key_matrix_out) |-> !key_irq_out ##1 key_irq_out)
    else $error("Stored state not followed by one irq.");

  a_irq_has_cause: assert property (
    key_irq_out |-> $past(key_matrix_out, 2) != $past(key_matrix_out))
    else $error("Interrupt without a new stored state.");

  a_keep_scanning: assert property (
    key_irq_out |-> scan_busy_out ##1 scan_busy_out [*8])
    else $error("Scanning stopped right after a report.");

  a_store_debounced: assert property (
    $changed(key_matrix_out) |->
      $past(scan_end) && $past(stable_inc) >= $past(debounce_scans_in))
    else $error("Matrix stored before the debounce count.");

  a_wake_from_idle: assert property (
    wake_out |-> $past(st_ff.fsm) == kms_pkg::KMS_IDLE && scan_busy_out)
    else $error("Wake pulse not tied to leaving idle.");

  c_press_report: cover property (
    wake_out ##[1:200] key_irq_out);
  c_two_reports: cover property (
    key_irq_out ##[1:400] key_irq_out);
  c_back_to_idle: cover property (
    key_irq_out ##[1:400] !scan_busy_out);

endmodule : kms_scanner
`default_nettype wire

/* File: src/kms_map.svh */
// Purpose: Constant map of the key matrix scanner.
// Assumes: Included by its bare name from the scanner source.
// Notes:   Definitions only.
`ifndef KMS_MAP_SVH
`define KMS_MAP_SVH

// Reset value of the stored key matrix (no key pressed).
`define KMS_MATRIX_RST      64'h0000_0000_0000_0000
// Row index at which every scan starts.
`define KMS_ROW_FIRST       3'h0
// Reset value of the stable scan counter.
`define KMS_STABLE_RST      16'h0000
// Phase of a row slot in which the row drives and the columns settle.
`define KMS_PHASE_SETTLE    1'h0
// Phase of a row slot in which the columns are sampled.
`define KMS_PHASE_SAMPLE    1'h1
// Intended scanner clock rate, in Hz; debounce is counted in scans of it.
`define KMS_CLK_HZ          32768

`endif

/* File: src/kms_pkg.sv */
// Purpose: Types shared by the key matrix scanner.
// Assumes: Nothing beyond the tool defaults.
// Notes:   Constants live in kms_map.svh.
package kms_pkg;

  // One-hot scanner states.
  typedef enum logic [1:0] {
    KMS_IDLE = 2'b01,
    KMS_SCAN = 2'b10
  } kms_fsm_type;

endpackage : kms_pkg

/* File: testbench/kms_keypad.sv */
// Purpose: Passive key switch matrix facing the scanner.
// Assumes: Columns are pulled low where no key joins a high row.
// Notes:   Pure wiring; no bounce is modelled.
`timescale 1ns/1ns
`default_nettype none
module kms_keypad (
  // Matrix pins and key pattern
  input  wire logic [7:0]  row_drive_in,
  input  wire logic [63:0] keys_in,
  output logic      [7:0]  col_sense_out
);
  always_comb begin
    col_sense_out = 8'h00;
    for (int r = 0; r < 8; r++) begin
      if (row_drive_in[r]) begin
        col_sense_out = col_sense_out | keys_in[r*8 +: 8];
      end
    end
  end
endmodule : kms_keypad
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the key matrix scanner.
// Assumes: One clock at 100 MHz and a passive matrix.
// Notes:   Debounce is counted in whole scans of 16 clocks.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  row_drive, col_sense;
  logic [15:0] deb = 16'h0001;
  logic [63:0] keys = 64'h0, matrix;
  logic        irq, wake, busy;
  int          mismatches = 0, checked = 0, cycles = 0, bad_rows = 0;
  int          n;
  bit          wake_seen = 0;

  kms_scanner uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .row_drive_out(row_drive), .col_sense_in(col_sense),
    .debounce_scans_in(deb), .key_matrix_out(matrix),
    .key_irq_out(irq), .wake_out(wake), .scan_busy_out(busy));
  kms_keypad pad (.row_drive_in(row_drive), .keys_in(keys),
    .col_sense_out(col_sense));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // A scan with other than one raised row would mix rows in the columns.
  always @(negedge clk_in) begin
    if (wake === 1'b1) wake_seen = 1;
    if (busy === 1'b1 && !$onehot(row_drive)) bad_rows++;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic press_wait(input logic [63:0] v, output int cnt);
    @(posedge clk_in);
    keys <= v;
    #1;
    cnt = 0;
    while (irq !== 1'b1 && cnt < 400) begin
      @(posedge clk_in);
      #1;
      cnt++;
    end
    chk({63'h0, cnt < 400}, 64'h1);
  endtask : press_wait

  task automatic t_press;
    press_wait(64'h0000_0000_0000_0001, n);
    chk(matrix, 64'h0000_0000_0000_0001);
    chk({63'h0, wake_seen}, 64'h1);
  endtask : t_press

  task automatic t_add;
    press_wait(64'h8000_0010_0000_0001, n);
    chk(matrix, 64'h8000_0010_0000_0001);
  endtask : t_add

  task automatic t_release;
    press_wait(64'h0, n);
    chk(matrix, 64'h0);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({56'h0, row_drive}, 64'hFF);
  endtask : t_release

  task automatic t_debounce;
    @(posedge clk_in);
    deb <= 16'h0003;
    press_wait(64'h0000_0000_0000_8000, n);
    // One new scan and three equal ones, 16 clocks each, precede the report.
    chk({63'h0, n >= 64}, 64'h1);
    chk(matrix, 64'h0000_0000_0000_8000);
  endtask : t_debounce

  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk({56'h0, row_drive}, 64'hFF);
    chk({busy, matrix[62:0]}, 64'h0);
    t_press();
    t_add();
    t_release();
    t_debounce();
    chk(64'(bad_rows), 64'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
